// ==== cfg_loader.sv ====
// Purpose: capture reset straps and run the serial ROM record loader
// Assumes: classic Wishbone slave on clk_i, serial ROM link on link_clk_i
// Notes: record writes outside the internal window go out on the ext port
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
module cfg_loader (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic link_clk_i,
	input wire logic [31:0] ad_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	output logic ext_wr_o,
	output cfg_loader_pkg::rec_s ext_req_o,
	input wire logic ext_ack_i,
	output cfg_loader_pkg::cpu_mode_e cpu_mode_o,
	output logic cpu_mode_rsv_o,
	output logic [31:0] int_base_o,
	output logic init_active_o,
	output logic init_done_o,
	output logic init_error_o,
	input wire logic sda_i,
	output logic scl_o,
	output logic scl_oe_n_o,
	output logic sda_o,
	output logic sda_oe_n_o
);
	// ------------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------------
	typedef enum logic [6:0] {
		M_BOOT = 7'b0000001,
		M_FETCH = 7'b0000010,
		M_WAIT = 7'b0000100,
		M_EXT = 7'b0001000,
		M_NEXT = 7'b0010000,
		M_DONE = 7'b0100000,
		M_ERR = 7'b1000000
	} main_e;

	typedef struct packed {
		main_e st;
		logic [31:0] ad_s1;
		logic [31:0] ad_s2;
		logic [31:0] strap;
		logic [31:0] last_item;
		logic [cfg_loader_pkg::ROM_AW:0] ptr;
		logic req_tgl;
		logic done_s1;
		logic done_s2;
		logic done_s3;
		logic nack_seen;
		logic ext_wr;
		cfg_loader_pkg::rec_s ext_req;
		logic ack;
		logic [31:0] rdat;
		cfg_loader_pkg::cpu_mode_e cpu_mode;
		logic cpu_rsv;
		logic [31:0] base;
		logic active;
		logic done;
		logic error;
	} main_s;

	main_s m;
	main_s next_m;
	logic link_done_tgl;
	logic link_nack;
	cfg_loader_pkg::rec_s link_rec;

	// ------------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------------
	// register write, shared by the bus and by records aimed at the internal window
	function automatic main_s reg_write(input main_s s, input logic [7:0] off,
		input logic [31:0] d, input logic [3:0] be);
		main_s t;
		t = s;
		if (off == cfg_loader_pkg::REG_LAST) begin
			for (int i = 0; i < 4; i++) begin
				if (be[i]) begin
					t.last_item[8*i +: 8] = d[8*i +: 8];
				end
			end
		end else if (off == cfg_loader_pkg::REG_CTRL && be[0]) begin
			// restart reruns the rom pass, only when the strap enabled it
			if (d[cfg_loader_pkg::CTRL_RESTART_BIT] && s.strap[cfg_loader_pkg::SROM_EN_BIT]
				&& !s.active) begin
				t.ptr = '0;
				t.done = 1'b0;
				t.error = 1'b0;
				t.nack_seen = 1'b0;
				t.active = 1'b1;
				t.st = M_FETCH;
			end
		end
		return t;
	endfunction

	function automatic logic [31:0] reg_read(input main_s s, input logic [7:0] off);
		case (off)
			cfg_loader_pkg::REG_CTRL: reg_read = 32'h0000_0000;
			cfg_loader_pkg::REG_STATUS: reg_read = {25'h0, s.cpu_rsv, s.cpu_mode, s.nack_seen,
				s.error, s.done, s.active};
			cfg_loader_pkg::REG_LAST: reg_read = s.last_item;
			cfg_loader_pkg::REG_STRAP: reg_read = s.strap;
			cfg_loader_pkg::REG_PTR: reg_read = {18'h0, s.ptr};
			default: reg_read = 32'h0000_0000;
		endcase
	endfunction

	function automatic logic in_window(input logic [31:0] a, input logic [31:0] base);
		in_window = a >= base && a < base + cfg_loader_pkg::INT_SPAN;
	endfunction

	// ------------------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------------------
	// strap capture, record loop and bus slave share one state copy
	always_comb begin
		logic [31:0] cap;
		logic [31:0] off;
		cap = 32'h0;
		off = 32'h0;
		next_m = m;
		next_m.ad_s1 = ad_i;
		next_m.ad_s2 = m.ad_s1;
		next_m.done_s1 = link_done_tgl;
		next_m.done_s2 = m.done_s1;
		next_m.done_s3 = m.done_s2;
		case (m.st)
			M_BOOT: begin
				// first cycle after reset release: straps are sampled here
				cap = m.ad_s2[cfg_loader_pkg::SROM_EN_BIT] ? (m.ad_s2 &
					cfg_loader_pkg::PARTIAL_MASK) : m.ad_s2;
				next_m.strap = cap;
				next_m.cpu_mode = cfg_loader_pkg::cpu_mode_e'(cap[cfg_loader_pkg::CPU_LSB +: 2]);
				next_m.cpu_rsv = cap[cfg_loader_pkg::CPU_LSB + 1];
				next_m.base = cap[cfg_loader_pkg::SPACE_BIT] ? cfg_loader_pkg::BASE_HIGH :
					cfg_loader_pkg::BASE_LOW;
				if (cap[cfg_loader_pkg::SROM_EN_BIT]) begin
					next_m.active = 1'b1;
					next_m.st = M_FETCH;
				end else begin
					next_m.done = 1'b1;
					next_m.st = M_DONE;
				end
			end
			M_FETCH: begin
				// pointer and device address hold still until the answer returns
				next_m.req_tgl = ~m.req_tgl;
				next_m.st = M_WAIT;
			end
			M_WAIT: begin
				if (m.done_s2 != m.done_s3) begin
					if (link_nack) begin
						next_m.nack_seen = 1'b1;
						next_m.error = 1'b1;
						next_m.active = 1'b0;
						next_m.st = M_ERR;
					end else if (link_rec.data == m.last_item) begin
						next_m.active = 1'b0;
						next_m.done = 1'b1;
						next_m.st = M_DONE;
					end else if (in_window(link_rec.addr, m.base)) begin
						off = link_rec.addr - m.base;
						next_m = reg_write(next_m, off[7:0], link_rec.data, 4'hf);
						next_m.ptr = m.ptr + cfg_loader_pkg::REC_BYTES;
						next_m.st = M_NEXT;
					end else begin
						next_m.ext_wr = 1'b1;
						next_m.ext_req = link_rec;
						next_m.st = M_EXT;
					end
				end
			end
			M_EXT: begin
				if (ext_ack_i) begin
					next_m.ext_wr = 1'b0;
					next_m.ptr = m.ptr + cfg_loader_pkg::REC_BYTES;
					next_m.st = M_NEXT;
				end
			end
			M_NEXT: begin
				// running off the end of the rom with no terminator is an error
				if (m.ptr[cfg_loader_pkg::ROM_AW]) begin
					next_m.error = 1'b1;
					next_m.active = 1'b0;
					next_m.st = M_ERR;
				end else begin
					next_m.st = M_FETCH;
				end
			end
			M_DONE: next_m.st = M_DONE;
			M_ERR: next_m.st = M_ERR;
			default: next_m.st = M_ERR;
		endcase
		// classic wishbone: ack one cycle after the strobe, dropped the cycle after
		next_m.ack = wb_cyc_i && wb_stb_i && !m.ack;
		if (wb_cyc_i && wb_stb_i && !m.ack) begin
			next_m.rdat = reg_read(m, wb_adr_i);
			if (wb_we_i) begin
				next_m = reg_write(next_m, wb_adr_i, wb_dat_i, wb_sel_i);
			end
		end
		if (rst_i) begin
			next_m.st = M_BOOT;
			next_m.strap = 32'h0;
			next_m.last_item = cfg_loader_pkg::LAST_ITEM_RST;
			next_m.ptr = '0;
			next_m.req_tgl = 1'b0;
			next_m.nack_seen = 1'b0;
			next_m.ext_wr = 1'b0;
			next_m.ext_req = '0;
			next_m.ack = 1'b0;
			next_m.rdat = 32'h0;
			next_m.cpu_mode = cfg_loader_pkg::CPU_60X;
			next_m.cpu_rsv = 1'b0;
			next_m.base = cfg_loader_pkg::BASE_LOW;
			next_m.active = 1'b0;
			next_m.done = 1'b0;
			next_m.error = 1'b0;
		end
	end

	// single state register; the synchroniser stages ride along in it
	always_ff @(posedge clk_i) begin
		m <= next_m;
	end

	// ------------------------------------------------------------------------
	// serial rom link
	// ------------------------------------------------------------------------
	// the rom strap picks one of four device addresses
	rom_record_reader u_reader (
		.link_clk_i(link_clk_i),
		.rst_i(rst_i),
		.req_tgl_i(m.req_tgl),
		.byte_addr_i(m.ptr[cfg_loader_pkg::ROM_AW-1:0]),
		.dev_addr_i(cfg_loader_pkg::ROM_DEV_BASE | {5'h0,
			m.strap[cfg_loader_pkg::ROM_SEL_LSB +: 2]}),
		.sda_i(sda_i),
		.done_tgl_o(link_done_tgl),
		.nack_o(link_nack),
		.rec_o(link_rec),
		.scl_o(scl_o),
		.scl_oe_n_o(scl_oe_n_o),
		.sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n_o)
	);

	// outputs straight from the state register
	assign wb_ack_o = m.ack;
	assign wb_dat_o = m.rdat;
	assign ext_wr_o = m.ext_wr;
	assign ext_req_o = m.ext_req;
	assign cpu_mode_o = m.cpu_mode;
	assign cpu_mode_rsv_o = m.cpu_rsv;
	assign int_base_o = m.base;
	assign init_active_o = m.active;
	assign init_done_o = m.done;
	assign init_error_o = m.error;

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_boot_mode_pick: assert property ((m.st == M_BOOT) |=> (m.st == M_FETCH) ||
		(m.st == M_DONE)) else $error("boot did not pick a start-up method");
	a_strap_full_latch: assert property ((m.st == M_BOOT && !m.ad_s2[0]) |=>
		(m.strap == $past(m.ad_s2)) && init_done_o)
		else $error("strap-only capture wrong");
	a_strap_partial: assert property ((m.st == M_BOOT && m.ad_s2[0]) |=>
		(m.strap == ($past(m.ad_s2) & cfg_loader_pkg::PARTIAL_MASK)) && init_active_o)
		else $error("partial strap capture wrong");
	a_enable_bit_gate: assert property ((m.st == M_FETCH) |-> m.strap[0])
		else $error("rom pass without enable strap");
	a_record_step: assert property ((m.st == M_NEXT) |-> m.ptr[2:0] == 3'h0 &&
		$past(m.st, 1) inside {M_WAIT, M_EXT}) else $error("record pointer misstep");
	a_last_item_stop: assert property ((m.st == M_WAIT && m.done_s2 != m.done_s3 &&
		!link_nack && link_rec.data == m.last_item) |=> m.st == M_DONE && !ext_wr_o)
		else $error("terminator did not stop loop");
	a_ext_decode: assert property ($rose(ext_wr_o) |-> !in_window(ext_req_o.addr, m.base))
		else $error("internal address sent outside");
	a_ext_hold: assert property ((ext_wr_o && !ext_ack_i) |=> ext_wr_o && $stable(ext_req_o))
		else $error("external write dropped early");
	a_cpu_reserved: assert property (cpu_mode_rsv_o == (cpu_mode_o inside
		{cfg_loader_pkg::CPU_RSV2, cfg_loader_pkg::CPU_RSV3}))
		else $error("reserved cpu mode flag wrong");
	a_space_base: assert property ((m.st != M_BOOT) |-> int_base_o ==
		(m.strap[5] ? cfg_loader_pkg::BASE_HIGH : cfg_loader_pkg::BASE_LOW))
		else $error("internal base mismatch");
	a_wb_ack_pulse: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1
		!wb_ack_o) else $error("bus ack not a single pulse");

	c_strap_only: cover property ((m.st == M_BOOT && !m.ad_s2[0]) ##1 init_done_o);
	c_ext_write: cover property (ext_wr_o ##[1:20] ext_ack_i);
	c_rom_finish: cover property ($rose(init_done_o) && m.ptr != 14'h0);
	c_rom_nack: cover property ($rose(init_error_o) && m.nack_seen);
endmodule

// ==== cfg_loader_pkg.sv ====
// Purpose: constants and carrier types for the start-up configuration loader
// Assumes: 32-bit strap bus, byte-addressed serial ROM of 8 KiB
// Notes: shared by the loader core and its serial ROM record reader
// ----------------------------------------------------------------------------
// Summary of operation
// - support strap-only and strap plus ROM start-up
// - strap-only: latch whole bus at reset release
// - ROM mode: latch partial straps, then fetch ROM
// - strap bit zero low skips, high runs ROM
// - read eight-byte address/data records, write them
// - stop when data equals last-item register
// - decode address: internal registers or external bus
// ----------------------------------------------------------------------------
package cfg_loader_pkg;
	// strap field positions
	localparam int SROM_EN_BIT = 0;
	localparam int ROM_SEL_LSB = 2;
	localparam int SPACE_BIT = 5;
	localparam int CPU_LSB = 6;
	// bits that are still taken from the pins when the ROM pass follows
	localparam logic [31:0] PARTIAL_MASK = 32'h0000_00ff;
	localparam logic [6:0] ROM_DEV_BASE = 7'h50;
	localparam logic [31:0] BASE_LOW = 32'h1400_0000;
	localparam logic [31:0] BASE_HIGH = 32'hf100_0000;
	localparam logic [31:0] INT_SPAN = 32'h0000_0020;
	localparam logic [31:0] LAST_ITEM_RST = 32'h0fff_ffff;
	// rom geometry
	localparam int ROM_AW = 13;
	localparam logic [ROM_AW:0] REC_BYTES = 14'h0008;
	// register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_LAST = 8'h08;
	localparam logic [7:0] REG_STRAP = 8'h0c;
	localparam logic [7:0] REG_PTR = 8'h10;
	localparam int CTRL_RESTART_BIT = 0;

	typedef enum logic [1:0] {
		CPU_60X = 2'b00,
		CPU_MPX = 2'b01,
		CPU_RSV2 = 2'b10,
		CPU_RSV3 = 2'b11
	} cpu_mode_e;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
	} rec_s;
endpackage

// ==== rom_model.sv ====
// Purpose: behavioural serial ROM answering the loader's record fetch
// Assumes: open-drain lines resolved in the bench with pull-ups
// Notes: answers only its own device address; pointer wraps at 8 KiB
`timescale 1ns/10ps
module rom_model (
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic [6:0] dev_i,
	output logic sda_low_o
);
	logic [7:0] mem [0:8191];
	logic [7:0] sh;
	logic [12:0] ptr;
	logic act, send, go, mack;
	int bitn, phase;
	initial begin
		act = 0;
		send = 0;
		sda_low_o = 0;
	end
	// start condition opens a frame, stop closes it
	always @(negedge sda_i) if (scl_i) begin
		act = 1;
		send = 0;
		go = 0;
		mack = 0;
		bitn = 0;
		phase = 0;
	end
	always @(posedge sda_i) if (scl_i) begin
		act = 0;
		sda_low_o = 0;
	end
	// sample while the clock is high
	always @(posedge scl_i) if (act) begin
		if (bitn < 8 && !send) sh = {sh[6:0], sda_i};
		if (bitn == 8 && send) mack = !sda_i;
		bitn++;
	end
	// change only on the falling clock so data never moves while high
	always @(negedge scl_i) if (act) begin
		if (bitn == 8 && !send) begin
			if (phase == 0) begin
				act = (sh[7:1] == dev_i); // wrong address gets no acknowledge
				go = sh[0];
			end else if (phase == 1) ptr[12:8] = sh[4:0];
			else ptr[7:0] = sh;
			phase++;
			sda_low_o = act;
		end else if (bitn == 8) sda_low_o = 0;
		else if (bitn == 9) begin
			bitn = 0;
			if (send) ptr++;
			if (go && !send) begin
				send = 1;
				mack = 1;
			end
			sda_low_o = send && mack && !mem[ptr][7];
		end else if (send) sda_low_o = mack && !mem[ptr][7 - bitn];
	end
endmodule

// ==== rom_record_reader.sv ====
// Purpose: fetch one eight-byte record from the serial ROM, on the link clock
// Assumes: link clock runs free; open-drain pins, enable low while driving low
// Notes: one bit per four link cycles; no clock stretching from the ROM
`timescale 1ns/10ps
module rom_record_reader (
	input wire logic link_clk_i,
	input wire logic rst_i,
	input wire logic req_tgl_i,
	input wire logic [cfg_loader_pkg::ROM_AW-1:0] byte_addr_i,
	input wire logic [6:0] dev_addr_i,
	input wire logic sda_i,
	output logic done_tgl_o,
	output logic nack_o,
	output cfg_loader_pkg::rec_s rec_o,
	output logic scl_o,
	output logic scl_oe_n_o,
	output logic sda_o,
	output logic sda_oe_n_o
);
	typedef enum logic [4:0] {
		L_IDLE = 5'b00001,
		L_START = 5'b00010,
		L_TX = 5'b00100,
		L_RX = 5'b01000,
		L_STOP = 5'b10000
	} link_e;

	typedef struct packed {
		logic rst_s1;
		logic rst_s2;
		logic req_s1;
		logic req_s2;
		logic req_s3;
		logic sda_s1;
		logic sda_s2;
		link_e st;
		logic [1:0] phase;
		logic [3:0] bitn;
		logic [3:0] step;
		logic [7:0] sh;
		logic [63:0] rec;
		logic nack;
		logic done_tgl;
		logic scl_oe_n;
		logic sda_oe_n;
	} link_s;

	link_s r;
	link_s next_r;

	// byte sent at each step of the read sequence
	function automatic logic [7:0] tx_byte(input logic [3:0] step);
		case (step)
			4'h0: tx_byte = {dev_addr_i, 1'b0};
			4'h1: tx_byte = {3'h0, byte_addr_i[12:8]};
			4'h2: tx_byte = byte_addr_i[7:0];
			default: tx_byte = {dev_addr_i, 1'b1};
		endcase
	endfunction

	// one bit slot: phase0 set sda (scl low), phase1 release scl, phase2 hold,
	// phase3 pull scl low and decide; the synced sda read at phase3 was taken at
	// phase1, so our own acknowledge from the slot before is already let go
	always_comb begin
		next_r = r;
		next_r.rst_s1 = rst_i;
		next_r.rst_s2 = r.rst_s1;
		next_r.req_s1 = req_tgl_i;
		next_r.req_s2 = r.req_s1;
		next_r.req_s3 = r.req_s2;
		next_r.sda_s1 = sda_i;
		next_r.sda_s2 = r.sda_s1;
		next_r.phase = r.st == L_IDLE ? 2'h0 : r.phase + 2'h1;
		case (r.st)
			L_IDLE: begin
				next_r.scl_oe_n = 1'b1;
				next_r.sda_oe_n = 1'b1;
				if (r.req_s2 != r.req_s3) begin
					next_r.step = 4'h0;
					next_r.nack = 1'b0;
					next_r.st = L_START;
				end
			end
			L_START: begin
				case (r.phase)
					2'h0: next_r.sda_oe_n = 1'b1;
					2'h1: next_r.scl_oe_n = 1'b1;
					2'h2: next_r.sda_oe_n = 1'b0; // sda falls with scl high: start
					default: begin
						next_r.scl_oe_n = 1'b0;
						next_r.st = L_TX;
						next_r.bitn = 4'h0;
						next_r.step = r.step == 4'h3 ? 4'h4 : r.step;
						next_r.sh = tx_byte(r.step == 4'h3 ? 4'h4 : r.step);
					end
				endcase
			end
			L_TX: begin
				case (r.phase)
					2'h0: next_r.sda_oe_n = r.bitn[3] ? 1'b1 : r.sh[7];
					2'h1: next_r.scl_oe_n = 1'b1;
					2'h2: next_r.scl_oe_n = 1'b1;
					default: begin
						next_r.scl_oe_n = 1'b0;
						next_r.bitn = r.bitn + 4'h1;
						next_r.sh = {r.sh[6:0], 1'b0};
						if (r.bitn[3]) begin
							next_r.bitn = 4'h0;
							next_r.step = r.step + 4'h1;
							if (r.sda_s2) begin
								next_r.nack = 1'b1;
								next_r.st = L_STOP;
							end else if (r.step == 4'h2) begin
								next_r.st = L_START;
							end else if (r.step == 4'h4) begin
								next_r.st = L_RX;
							end else begin
								next_r.sh = tx_byte(r.step + 4'h1);
							end
						end
					end
				endcase
			end
			L_RX: begin
				case (r.phase)
					// acknowledge all but the last byte
					2'h0: next_r.sda_oe_n = r.bitn[3] ? (r.step == 4'hc) : 1'b1;
					2'h1: next_r.scl_oe_n = 1'b1;
					2'h2: next_r.scl_oe_n = 1'b1;
					default: begin
						next_r.scl_oe_n = 1'b0;
						next_r.bitn = r.bitn + 4'h1;
						next_r.sh = {r.sh[6:0], r.sda_s2};
						if (r.bitn == 4'h7) begin
							next_r.rec = {r.rec[55:0], r.sh[6:0], r.sda_s2};
						end
						if (r.bitn[3]) begin
							next_r.bitn = 4'h0;
							next_r.step = r.step + 4'h1;
							next_r.st = r.step == 4'hc ? L_STOP : L_RX;
						end
					end
				endcase
			end
			L_STOP: begin
				case (r.phase)
					2'h0: next_r.sda_oe_n = 1'b0;
					2'h1: next_r.scl_oe_n = 1'b1;
					2'h2: next_r.sda_oe_n = 1'b1; // sda rises with scl high: stop
					default: begin
						next_r.scl_oe_n = 1'b1;
						next_r.done_tgl = ~r.done_tgl;
						next_r.st = L_IDLE;
					end
				endcase
			end
			default: next_r.st = L_IDLE;
		endcase
		if (r.rst_s2) begin
			next_r.st = L_IDLE;
			next_r.phase = 2'h0;
			next_r.bitn = 4'h0;
			next_r.step = 4'h0;
			next_r.sh = 8'h00;
			next_r.rec = 64'h0;
			next_r.nack = 1'b0;
			next_r.done_tgl = 1'b0;
			next_r.scl_oe_n = 1'b1;
			next_r.sda_oe_n = 1'b1;
			next_r.req_s3 = r.req_s2; // a toggle seen during reset is not a request
		end
	end

	always_ff @(posedge link_clk_i) begin
		r <= next_r;
	end

	assign done_tgl_o = r.done_tgl;
	assign nack_o = r.nack;
	assign rec_o = r.rec;
	assign scl_o = r.rst_s2 & 1'b0;
	assign scl_oe_n_o = r.scl_oe_n;
	assign sda_o = r.rst_s2 & 1'b0;
	assign sda_oe_n_o = r.sda_oe_n;
endmodule

// ==== tb_cfg_loader.sv ====
// Purpose: self-checking bench for the start-up configuration loader
// Assumes: serial ROM model on the link, bench acks external writes
// Notes: reset is held long enough for the link domain as well
`timescale 1ns/10ps
module tb_cfg_loader;
	logic clk_i, rst_i, link_clk_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ext_wr_o, ext_ack_i;
	logic cpu_mode_rsv_o, init_active_o, init_done_o, init_error_o, rom_low;
	logic scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, scl_w, sda_w;
	logic [31:0] ad_i, wb_dat_i, wb_dat_o, int_base_o, q;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [6:0] rom_dev;
	cfg_loader_pkg::rec_s ext_req_o, ext_seen;
	cfg_loader_pkg::cpu_mode_e cpu_mode_o;
	int n_fail, tests_run, ext_cnt, stall;

	cfg_loader i_dut (.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i), .ad_i(ad_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
		.ext_wr_o(ext_wr_o), .ext_req_o(ext_req_o), .ext_ack_i(ext_ack_i),
		.cpu_mode_o(cpu_mode_o), .cpu_mode_rsv_o(cpu_mode_rsv_o), .int_base_o(int_base_o),
		.init_active_o(init_active_o), .init_done_o(init_done_o), .init_error_o(init_error_o),
		.sda_i(sda_w), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n_o));
	rom_model i_rom (.scl_i(scl_w), .sda_i(sda_w), .dev_i(rom_dev), .sda_low_o(rom_low));

	// open-drain wires: released lines float high on the pull-ups
	assign scl_w = scl_oe_n_o ? 1'b1 : scl_o;
	assign sda_w = (sda_oe_n_o ? 1'b1 : sda_o) & ~rom_low;

	// clocks, unrelated in phase
	initial begin
		clk_i = 0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		link_clk_i = 0;
		#7;
		forever #32 link_clk_i = ~link_clk_i;
	end

	// external target stalls three cycles before it acknowledges
	always @(posedge clk_i) begin
		ext_ack_i <= ext_wr_o === 1'b1 && !ext_ack_i && stall == 3;
		if (ext_wr_o === 1'b1 && !ext_ack_i) begin
			stall <= stall == 3 ? 0 : stall + 1;
			if (stall == 3) begin
				ext_seen <= ext_req_o;
				ext_cnt <= ext_cnt + 1;
			end
		end
	end

	// --------------------------------------------------------------
	// shared tasks
	// --------------------------------------------------------------
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask
	// classic cycle; the master never assumes how soon ack comes
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, s};
		// only the watchdog ends a wait for ack
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic boot(input logic [31:0] ad);
		@(posedge clk_i);
		rst_i <= 1'b1;
		ad_i <= ad;
		repeat (30) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic wait_end;
		int n;
		n = 0;
		while (init_done_o !== 1'b1 && init_error_o !== 1'b1 && n < 20000) begin
			@(posedge clk_i);
			n++;
		end
		if (n == 20000) chk("pass end", 32'h1, 32'h0);
	endtask
	task automatic load_rec(input int i, input logic [31:0] a, input logic [31:0] d);
		logic [63:0] r;
		r = {a, d};
		for (int b = 0; b < 8; b++) i_rom.mem[i * 8 + b] = r[63 - b * 8 -: 8];
	endtask

	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	task automatic t_straps;
		logic [31:0] ad;
		for (int k = 0; k < 4; k++) begin
			ad = {16'ha5c3, 8'h5a, k[1:0], k[0], 5'h12};
			boot(ad);
			chk("done", 32'h1, {31'h0, init_done_o});
			chk("active", 32'h0, {31'h0, init_active_o});
			chk("cpu mode", k, {30'h0, cpu_mode_o});
			chk("cpu rsv", {31'h0, k[1]}, {31'h0, cpu_mode_rsv_o});
			chk("base", k[0] ? 32'hf100_0000 : 32'h1400_0000, int_base_o);
			wb(1'b0, cfg_loader_pkg::REG_STRAP, 32'h0, 4'hf);
			chk("strap", ad, q);
		end
		$display("test straps done");
	endtask
	task automatic t_regs;
		wb(1'b0, cfg_loader_pkg::REG_LAST, 32'h0, 4'hf);
		chk("last reset", 32'h0fff_ffff, q);
		wb(1'b1, cfg_loader_pkg::REG_LAST, 32'haabb_ccdd, 4'h3);
		wb(1'b0, cfg_loader_pkg::REG_LAST, 32'h0, 4'hf);
		chk("last bytes", 32'h0fff_ccdd, q);
		wb(1'b1, cfg_loader_pkg::REG_STATUS, 32'h0, 4'hf);
		wb(1'b0, cfg_loader_pkg::REG_STATUS, 32'h0, 4'hf);
		chk("status", 32'h72, q);
		wb(1'b0, 8'h40, 32'h0, 4'hf);
		chk("unmapped", 32'h0, q);
		wb(1'b1, cfg_loader_pkg::REG_CTRL, 32'h1, 4'hf);
		repeat (3) @(posedge clk_i);
		chk("no restart", 32'h0, {31'h0, init_active_o});
		$display("test registers done");
	endtask
	task automatic t_rom_pass;
		int c0;
		rom_dev = 7'h52;
		load_rec(0, 32'h1400_0008, 32'h1234_5678);
		load_rec(1, 32'h8000_0010, 32'hcafe_0001);
		load_rec(2, 32'h8000_0020, 32'h1234_5678);
		c0 = ext_cnt;
		boot(32'hffff_0009);
		chk("rom active", 32'h1, {31'h0, init_active_o});
		chk("rom base", 32'h1400_0000, int_base_o);
		wait_end;
		chk("rom done", 32'h1, {31'h0, init_done_o});
		chk("rom error", 32'h0, {31'h0, init_error_o});
		chk("ext count", 32'h1, 32'(ext_cnt - c0));
		chk("ext addr", 32'h8000_0010, ext_seen.addr);
		chk("ext data", 32'hcafe_0001, ext_seen.data);
		wb(1'b0, cfg_loader_pkg::REG_LAST, 32'h0, 4'hf);
		chk("internal write", 32'h1234_5678, q);
		wb(1'b0, cfg_loader_pkg::REG_STRAP, 32'h0, 4'hf);
		chk("partial strap", 32'h9, q);
		// two records advanced the pointer; the terminator does not
		wb(1'b0, cfg_loader_pkg::REG_PTR, 32'h0, 4'hf);
		chk("rom pointer", 32'h10, q);
		chk("pin levels", 32'h0, {30'h0, scl_o, sda_o});
		$display("test rom pass done");
	endtask
	task automatic t_rom_nack;
		int n;
		boot(32'h0000_0005);
		wait_end;
		chk("nack error", 32'h1, {31'h0, init_error_o});
		wb(1'b0, cfg_loader_pkg::REG_STATUS, 32'h0, 4'hf);
		chk("nack status", 32'h0c, q);
		wb(1'b1, cfg_loader_pkg::REG_CTRL, 32'h1, 4'hf);
		n = 0;
		while (init_active_o !== 1'b1 && n < 5) begin
			@(posedge clk_i);
			n++;
		end
		chk("restart", 32'h1, {31'h0, init_active_o});
		$display("test rom nack done");
	endtask

	// watchdog: the whole run needs well under a third of this
	initial begin
		repeat (100000) @(posedge clk_i);
		n_fail++;
		$display("watchdog expired");
		give_verdict;
	end
	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
		{rst_i, ad_i, ext_ack_i, ext_cnt, stall, n_fail, tests_run} = {1'b1, 161'h0};
		rom_dev = 7'h52;
		// short start-up reset; the boot task then holds a long one in every scenario but t_regs
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		t_straps;
		t_regs;
		t_rom_pass;
		t_rom_nack;
		give_verdict;
	end
endmodule
